// ===== shared/route_adder_pkg.sv
`default_nettype none
package route_adder_pkg;
    localparam int NUM_ROUTES = 3;
    localparam int SAMPLE_W   = 16;
    localparam int ROUTE_W    = SAMPLE_W + 2;
    localparam int SUM_W      = SAMPLE_W + 4;
    localparam int FRAC_BITS  = 15;
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 32;
    localparam int PIPE_LATENCY = 2;

    localparam logic [ADDR_W-1:0] CTRL_OFS       = 8'h00;
    localparam logic [ADDR_W-1:0] OVF_COUNT_OFS  = 8'h04;
    localparam logic [ADDR_W-1:0] STATUS_OFS     = 8'h08;
    localparam logic [ADDR_W-1:0] MASK_OFS       = 8'h0c;
    localparam logic [ADDR_W-1:0] ROUTE_BASE_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] ROUTE_STRIDE   = 8'h08;
    localparam logic [ADDR_W-1:0] ROUTE_GAIN_OFS = 8'h04;

    localparam int ENABLE_BIT    = 0;
    localparam int SRC_LSB       = 8;
    localparam int AMP_LSB       = 0;
    localparam int PHASE_LSB     = 16;
    localparam int ST_OVF_BIT    = 0;
    localparam int ST_BADSRC_BIT = 1;
    localparam int NUM_EVENTS    = 2;

    localparam logic [NUM_EVENTS-1:0] STATUS_RST = 2'h0;
    localparam logic [NUM_EVENTS-1:0] MASK_RST   = 2'h0;
    localparam logic [15:0]           AMP_RST    = 16'h0000;
    localparam logic [15:0]           PHASE_RST  = 16'h0000;

    // One quarter of a sine wave in 16 steps, full scale 0x7fff.
    localparam logic signed [15:0] SINE_QUARTER [0:16] = '{
        16'h0000, 16'h0c8c, 16'h18f9, 16'h2528, 16'h30fb, 16'h3c56,
        16'h471c, 16'h5133, 16'h5a82, 16'h62f1, 16'h6a6d, 16'h70e2,
        16'h7641, 16'h7a7c, 16'h7d89, 16'h7f61, 16'h7fff};
endpackage : route_adder_pkg
`default_nettype wire

// ===== shared/route_cfg_if.sv
`timescale 1ns/100ps
`default_nettype none
interface route_cfg_if #(
    parameter int SEL_W = 2
);
    logic             enable;
    logic [SEL_W-1:0] source;
    logic [15:0]      amplitude;
    logic [15:0]      phase;

    modport ctrl (output enable, output source, output amplitude, output phase);
    modport term (input enable, input source, input amplitude, input phase);
endinterface : route_cfg_if
`default_nettype wire

// ===== hw/route_term.sv
`timescale 1ns/100ps
`default_nettype none
module route_term
    import route_adder_pkg::*;
#(
    parameter int NUM_CH = 4,
    parameter int SEL_W  = 2
) (
    input  wire logic                           clk,
    input  wire logic                           rst,
    route_cfg_if.term                           cfg,
    input  wire logic [NUM_CH*SAMPLE_W-1:0]     src_i,
    input  wire logic [NUM_CH*SAMPLE_W-1:0]     src_q,
    output var  logic signed [ROUTE_W-1:0]      rot_i,
    output var  logic signed [ROUTE_W-1:0]      rot_q
);
    logic signed [SAMPLE_W-1:0] sel_i;
    logic signed [SAMPLE_W-1:0] sel_q;
    logic signed [15:0]         sin_v;
    logic signed [15:0]         cos_v;
    logic signed [31:0]         coef_cp;
    logic signed [31:0]         coef_sp;
    logic signed [15:0]         coef_c;
    logic signed [15:0]         coef_s;
    logic signed [32:0]         acc_i;
    logic signed [32:0]         acc_q;
    logic signed [ROUTE_W-1:0]  next_rot_i;
    logic signed [ROUTE_W-1:0]  next_rot_q;

    if (SEL_W < 1 || NUM_CH < 2 || NUM_CH > (1 << SEL_W)) begin
        $error("route_term: unsupported parameter values.");
    end

    // Phase resolution is 1/64 turn; finer phase bits are ignored to keep the table small.
    function automatic logic signed [15:0] sine_of(input logic [5:0] p);
        logic [4:0] k;
        k = {1'b0, p[3:0]};
        unique case (p[5:4])
            2'h0: sine_of = SINE_QUARTER[k];
            2'h1: sine_of = SINE_QUARTER[5'h10 - k];
            2'h2: sine_of = -SINE_QUARTER[k];
            2'h3: sine_of = -SINE_QUARTER[5'h10 - k];
        endcase
    endfunction : sine_of

    always_comb begin
        sel_i   = src_i[cfg.source*SAMPLE_W +: SAMPLE_W];
        sel_q   = src_q[cfg.source*SAMPLE_W +: SAMPLE_W];
        sin_v   = sine_of(cfg.phase[15:10]);
        cos_v   = sine_of(6'(cfg.phase[15:10] + 6'h10));
        coef_cp = $signed(cfg.amplitude) * cos_v;
        coef_sp = $signed(cfg.amplitude) * sin_v;
        coef_c  = 16'(coef_cp >>> FRAC_BITS);
        coef_s  = 16'(coef_sp >>> FRAC_BITS);
        // Operands are widened first so that the products keep all their bits.
        acc_i   = 33'(sel_i) * 33'(coef_c) - 33'(sel_q) * 33'(coef_s);
        acc_q   = 33'(sel_i) * 33'(coef_s) + 33'(sel_q) * 33'(coef_c);
        next_rot_i = ROUTE_W'(acc_i >>> FRAC_BITS);
        next_rot_q = ROUTE_W'(acc_q >>> FRAC_BITS);
        if (!cfg.enable) begin
            next_rot_i = '0;
            next_rot_q = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rot_i <= '0;
            rot_q <= '0;
        end else begin
            rot_i <= next_rot_i;
            rot_q <= next_rot_q;
        end
    end

    a_disabled_route_zero: assert property (@(posedge clk) disable iff (rst)
        !cfg.enable |=> (rot_i == '0) && (rot_q == '0))
        else $error("Disabled route produced a nonzero term.");

    a_full_gain_pass: assert property (@(posedge clk) disable iff (rst)
        (cfg.enable && cfg.phase == 16'h0000 && cfg.amplitude == 16'h7fff && sel_i == '0)
        |=> (rot_i == '0) && ($past(sel_q) - rot_q <= 2) && ($past(sel_q) - rot_q >= -2))
        else $error("Unrotated full gain route did not pass its source.");
endmodule : route_term
`default_nettype wire

// ===== hw/output_route_adder.sv
`timescale 1ns/100ps
`default_nettype none
module output_route_adder
    import route_adder_pkg::*;
#(
    parameter int NUM_CH   = 4,
    parameter int CH_INDEX = 0,
    parameter int CNT_W    = 32
) (
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire logic [ADDR_W-1:0]              reg_addr,
    input  wire logic [DATA_W-1:0]              reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output var  logic [DATA_W-1:0]              reg_rdata,
    input  wire logic                           in_valid,
    input  wire logic signed [SAMPLE_W-1:0]     own_i,
    input  wire logic signed [SAMPLE_W-1:0]     own_q,
    input  wire logic                           own_marker,
    input  wire logic [NUM_CH*SAMPLE_W-1:0]     src_i,
    input  wire logic [NUM_CH*SAMPLE_W-1:0]     src_q,
    output var  logic                           out_valid,
    output var  logic signed [SAMPLE_W-1:0]     out_i,
    output var  logic signed [SAMPLE_W-1:0]     out_q,
    output var  logic                           marker_out,
    output var  logic                           irq
);
    localparam int SEL_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
    localparam logic signed [SUM_W-1:0] SUM_HI = SUM_W'(2 ** (SAMPLE_W - 1) - 1);
    localparam logic signed [SUM_W-1:0] SUM_LO = SUM_W'(-(2 ** (SAMPLE_W - 1)));
    localparam logic [CNT_W-1:0]        CNT_MAX = '1;

    if (NUM_CH < 2 || CH_INDEX < 0 || CH_INDEX >= NUM_CH || CNT_W < 1 || CNT_W > DATA_W) begin
        $error("output_route_adder: unsupported parameter values.");
    end

    logic                          router_en;
    logic                          next_router_en;
    logic [NUM_ROUTES-1:0]         route_en;
    logic [NUM_ROUTES-1:0]         next_route_en;
    logic [SEL_W-1:0]              route_src [NUM_ROUTES];
    logic [SEL_W-1:0]              next_route_src [NUM_ROUTES];
    logic [15:0]                   route_amp [NUM_ROUTES];
    logic [15:0]                   next_route_amp [NUM_ROUTES];
    logic [15:0]                   route_phase [NUM_ROUTES];
    logic [15:0]                   next_route_phase [NUM_ROUTES];
    logic [NUM_EVENTS-1:0]         status;
    logic [NUM_EVENTS-1:0]         next_status;
    logic [NUM_EVENTS-1:0]         mask;
    logic [NUM_EVENTS-1:0]         next_mask;
    logic [NUM_EVENTS-1:0]         events;
    logic [CNT_W-1:0]              ovf_count;
    logic [CNT_W-1:0]              next_ovf_count;
    logic [DATA_W-1:0]             next_rdata;
    logic                          next_irq;
    logic [NUM_ROUTES-1:0]         bad_src;
    logic [NUM_ROUTES-1:0]         route_active;
    logic signed [ROUTE_W-1:0]     route_i [NUM_ROUTES];
    logic signed [ROUTE_W-1:0]     route_q [NUM_ROUTES];

    logic                          valid_d;
    logic signed [SAMPLE_W-1:0]    own_i_d;
    logic signed [SAMPLE_W-1:0]    own_q_d;
    logic                          marker_d;
    logic signed [SUM_W-1:0]       sum_i;
    logic signed [SUM_W-1:0]       sum_q;
    logic                          range_i;
    logic                          range_q;
    logic                          ovf_event;
    logic signed [SAMPLE_W-1:0]    next_out_i;
    logic signed [SAMPLE_W-1:0]    next_out_q;

    // Three route terms, each with its own configuration bundle.
    for (genvar m = 0; m < NUM_ROUTES; m++) begin : g_route
        route_cfg_if #(.SEL_W(SEL_W)) rc ();

        // A self-sourced route is held off rather than building a feedback loop.
        assign bad_src[m]      = route_en[m] && (route_src[m] == SEL_W'(CH_INDEX));
        assign route_active[m] = router_en && route_en[m] && !bad_src[m];
        assign rc.enable       = route_active[m];
        assign rc.source       = route_src[m];
        assign rc.amplitude    = route_amp[m];
        assign rc.phase        = route_phase[m];

        route_term #(
            .NUM_CH (NUM_CH),
            .SEL_W  (SEL_W)
        ) u_term (
            .clk   (clk),
            .rst   (rst),
            .cfg   (rc.term),
            .src_i (src_i),
            .src_q (src_q),
            .rot_i (route_i[m]),
            .rot_q (route_q[m])
        );

        a_self_source_off: assert property (@(posedge clk) disable iff (rst)
            (route_en[m] && route_src[m] == SEL_W'(CH_INDEX)) |-> !rc.enable)
            else $error("Route drawing from its own channel was left active.");
    end

    // Register file and status.
    always_comb begin
        next_router_en = router_en;
        next_route_en  = route_en;
        next_route_src = route_src;
        next_route_amp = route_amp;
        next_route_phase = route_phase;
        next_mask      = mask;
        next_rdata     = '0;
        events         = '0;
        events[ST_OVF_BIT]    = ovf_event;
        events[ST_BADSRC_BIT] = router_en && (|bad_src);
        next_status    = status;
        if (reg_wr && reg_addr == CTRL_OFS) begin
            next_router_en = reg_wdata[ENABLE_BIT];
        end
        if (reg_wr && reg_addr == MASK_OFS) begin
            next_mask = reg_wdata[NUM_EVENTS-1:0];
        end
        if (reg_wr && reg_addr == STATUS_OFS) begin
            next_status = status & ~reg_wdata[NUM_EVENTS-1:0];
        end
        // A new event in the clearing cycle survives the clear.
        next_status = next_status | events;
        for (int m = 0; m < NUM_ROUTES; m++) begin
            if (reg_wr && reg_addr == 8'(ROUTE_BASE_OFS + 8'(m) * ROUTE_STRIDE)) begin
                next_route_en[m]  = reg_wdata[ENABLE_BIT];
                next_route_src[m] = reg_wdata[SRC_LSB +: SEL_W];
            end
            if (reg_wr && reg_addr ==
                8'(ROUTE_BASE_OFS + 8'(m) * ROUTE_STRIDE + ROUTE_GAIN_OFS)) begin
                next_route_amp[m]   = reg_wdata[AMP_LSB +: 16];
                next_route_phase[m] = reg_wdata[PHASE_LSB +: 16];
            end
        end
        if (reg_rd) begin
            if (reg_addr == CTRL_OFS) begin
                next_rdata[ENABLE_BIT] = router_en;
            end
            if (reg_addr == OVF_COUNT_OFS) begin
                next_rdata[CNT_W-1:0] = ovf_count;
            end
            if (reg_addr == STATUS_OFS) begin
                next_rdata[NUM_EVENTS-1:0] = status;
            end
            if (reg_addr == MASK_OFS) begin
                next_rdata[NUM_EVENTS-1:0] = mask;
            end
            for (int m = 0; m < NUM_ROUTES; m++) begin
                if (reg_addr == 8'(ROUTE_BASE_OFS + 8'(m) * ROUTE_STRIDE)) begin
                    next_rdata[ENABLE_BIT]          = route_en[m];
                    next_rdata[SRC_LSB +: SEL_W]    = route_src[m];
                end
                if (reg_addr ==
                    8'(ROUTE_BASE_OFS + 8'(m) * ROUTE_STRIDE + ROUTE_GAIN_OFS)) begin
                    next_rdata[AMP_LSB +: 16]   = route_amp[m];
                    next_rdata[PHASE_LSB +: 16] = route_phase[m];
                end
            end
        end
        next_irq = |(next_status & next_mask);
        next_ovf_count = ovf_count;
        // The counter saturates so that a long run never wraps back to zero.
        if (ovf_event && ovf_count != CNT_MAX) begin
            next_ovf_count = CNT_W'(ovf_count + 1'b1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            router_en   <= 1'b0;
            route_en    <= '0;
            route_src   <= '{default: '0};
            route_amp   <= '{default: AMP_RST};
            route_phase <= '{default: PHASE_RST};
            status      <= STATUS_RST;
            mask        <= MASK_RST;
            ovf_count   <= '0;
            reg_rdata   <= '0;
            irq         <= 1'b0;
        end else begin
            router_en   <= next_router_en;
            route_en    <= next_route_en;
            route_src   <= next_route_src;
            route_amp   <= next_route_amp;
            route_phase <= next_route_phase;
            status      <= next_status;
            mask        <= next_mask;
            ovf_count   <= next_ovf_count;
            reg_rdata   <= next_rdata;
            irq         <= next_irq;
        end
    end

    // Datapath: stage one aligns the own channel with the route terms, stage two sums.
    always_comb begin
        sum_i = SUM_W'(own_i_d);
        sum_q = SUM_W'(own_q_d);
        for (int m = 0; m < NUM_ROUTES; m++) begin
            sum_i = sum_i + SUM_W'(route_i[m]);
            sum_q = sum_q + SUM_W'(route_q[m]);
        end
        range_i   = (sum_i > SUM_HI) || (sum_i < SUM_LO);
        range_q   = (sum_q > SUM_HI) || (sum_q < SUM_LO);
        ovf_event = valid_d && (range_i || range_q);
        // Clamping at the offending sample itself keeps the first overflow from wrapping.
        next_out_i = (sum_i > SUM_HI) ? SAMPLE_W'(SUM_HI) :
                     (sum_i < SUM_LO) ? SAMPLE_W'(SUM_LO) : SAMPLE_W'(sum_i);
        next_out_q = (sum_q > SUM_HI) ? SAMPLE_W'(SUM_HI) :
                     (sum_q < SUM_LO) ? SAMPLE_W'(SUM_LO) : SAMPLE_W'(sum_q);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            valid_d    <= 1'b0;
            own_i_d    <= '0;
            own_q_d    <= '0;
            marker_d   <= 1'b0;
            out_valid  <= 1'b0;
            out_i      <= '0;
            out_q      <= '0;
            marker_out <= 1'b0;
        end else begin
            valid_d    <= in_valid;
            own_i_d    <= own_i;
            own_q_d    <= own_q;
            marker_d   <= own_marker;
            out_valid  <= valid_d;
            out_i      <= next_out_i;
            out_q      <= next_out_q;
            marker_out <= marker_d;
        end
    end

    a_latency_fixed: assert property (@(posedge clk) disable iff (rst)
        in_valid |-> ##2 out_valid)
        else $error("Sample did not leave after two cycles.");

    a_marker_own: assert property (@(posedge clk) disable iff (rst)
        ##2 (marker_out == $past(own_marker, 2)))
        else $error("Marker output is not the own channel marker.");

    a_bypass_when_off: assert property (@(posedge clk) disable iff (rst)
        !router_en ##1 !router_en ##1 !router_en |->
        (out_i == $past(own_i, 2)) && (out_q == $past(own_q, 2)))
        else $error("Disabled router altered the own channel signal.");

    a_clamp_high: assert property (@(posedge clk) disable iff (rst)
        (sum_i > SUM_HI) |=> (out_i == 16'h7fff))
        else $error("Positive overflow was not saturated.");

    a_clamp_low: assert property (@(posedge clk) disable iff (rst)
        (sum_q < SUM_LO) |=> (out_q == 16'h8000))
        else $error("Negative overflow was not saturated.");

    a_count_step: assert property (@(posedge clk) disable iff (rst)
        (ovf_event && ovf_count != CNT_MAX) |=> (ovf_count == $past(ovf_count) + 1'b1))
        else $error("Overflow counter did not advance by one.");

    a_count_hold: assert property (@(posedge clk) disable iff (rst)
        !ovf_event |=> $stable(ovf_count))
        else $error("Overflow counter moved without an overflow.");

    a_status_set_wins: assert property (@(posedge clk) disable iff (rst)
        (ovf_event && reg_wr && reg_addr == STATUS_OFS) |=> status[ST_OVF_BIT])
        else $error("Overflow event lost to a simultaneous clear.");

    a_irq_level: assert property (@(posedge clk) disable iff (rst)
        irq == |(status & mask))
        else $error("Interrupt does not follow masked status.");
endmodule : output_route_adder
`default_nettype wire

// ===== verif/dac_sink.sv
`timescale 1ns/100ps
`default_nettype none
module dac_sink
    import route_adder_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       valid,
    input  wire logic signed [SAMPLE_W-1:0] data_i,
    input  wire logic signed [SAMPLE_W-1:0] data_q,
    output var  logic signed [SAMPLE_W-1:0] last_i,
    output var  logic signed [SAMPLE_W-1:0] last_q,
    output var  logic [15:0]                taken
);
    // The converter sees digital codes only; a code is latched only when marked valid.
    always_ff @(posedge clk) begin
        if (rst) begin
            last_i <= '0;
            last_q <= '0;
            taken  <= '0;
        end else if (valid) begin
            last_i <= data_i;
            last_q <= data_q;
            taken  <= taken + 16'h0001;
        end
    end
endmodule : dac_sink
`default_nettype wire

// ===== verif/output_route_adder_tb.sv
`timescale 1ns/100ps
`default_nettype none
module output_route_adder_tb
    import route_adder_pkg::*;
;
    logic                       clk = 1'b0, rst = 1'b1;
    logic [ADDR_W-1:0]          reg_addr = '0;
    logic [DATA_W-1:0]          reg_wdata = '0, reg_rdata;
    logic                       reg_wr = 1'b0, reg_rd = 1'b0, in_valid = 1'b0, own_marker = 1'b0;
    logic signed [SAMPLE_W-1:0] own_i = '0, own_q = '0, out_i, out_q, dac_i, dac_q;
    logic [4*SAMPLE_W-1:0]      src_i = '0, src_q = '0;
    logic                       out_valid, marker_out, irq;
    logic [15:0]                dac_n;
    logic [15:0]                amps [3] = '{16'h2000, 16'h1800, 16'h4000};
    logic [15:0]                phs [3]  = '{16'h4000, 16'h8000, 16'hd400};
    int                         err_total = 0, comparisons = 0, ei, eq;

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

    always #12.5 clk = ~clk;

    output_route_adder #(.NUM_CH(4), .CH_INDEX(0), .CNT_W(32)) uut (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid), .own_i(own_i),
        .own_q(own_q), .own_marker(own_marker), .src_i(src_i), .src_q(src_q),
        .out_valid(out_valid), .out_i(out_i), .out_q(out_q), .marker_out(marker_out),
        .irq(irq));

    dac_sink dac (.clk(clk), .rst(rst), .valid(out_valid), .data_i(out_i), .data_q(out_q),
        .last_i(dac_i), .last_q(dac_q), .taken(dac_n));

    function automatic int sn(input int k);
        int v;
        v = (k & 16) ? int'(SINE_QUARTER[16 - (k & 15)]) : int'(SINE_QUARTER[k & 15]);
        return (k & 32) ? -v : v;
    endfunction : sn

    function automatic int rot(input int si, input int sq, input int amp, input int ph,
                               input bit q);
        int k, c, s;
        k = (ph >> 10) & 63;
        c = (amp * sn((k + 16) & 63)) >>> 15;
        s = (amp * sn(k)) >>> 15;
        return q ? (si * s + sq * c) >>> 15 : (si * c - sq * s) >>> 15;
    endfunction : rot

    function automatic logic [15:0] sat(input int x);
        return (x > 32767) ? 16'h7fff : (x < -32768) ? 16'h8000 : x[15:0];
    endfunction : sat

    function automatic int ch(input logic [63:0] bus, input int k);
        return int'($signed(bus[16*k +: 16]));
    endfunction : ch

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, e)
    endtask : rd

    // Drives one sample and returns once its result stands at the outputs.
    task automatic push(input logic [15:0] oi, input logic [15:0] oq, input logic v,
                        input logic mk);
        @(posedge clk);
        own_i      <= oi;
        own_q      <= oq;
        in_valid   <= v;
        own_marker <= mk;
        @(posedge clk);
        in_valid   <= 1'b0;
        own_marker <= 1'b0;
        @(posedge clk);
        #1;
    endtask : push

    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
    endtask : do_reset

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("watchdog expired");
        tally_and_finish();
    end

    initial begin
        do_reset();
        for (int a = 0; a <= 40; a += 4) begin
            rd((a == 40) ? 8'hf0 : 8'(a), 32'h0);
        end
        wr(8'hf0, 32'hffff_ffff);
        wr(OVF_COUNT_OFS, 32'h0000_0055);
        rd(8'hf0, 32'h0);
        rd(OVF_COUNT_OFS, 32'h0);
        $display("test registers done");
        src_i <= {16'h0c00, 16'h0800, 16'h3000, 16'h1234};
        src_q <= {16'hfc00, 16'h0600, 16'hf000, 16'h0777};
        wr(ROUTE_BASE_OFS, 32'h0000_0101);
        wr(ROUTE_GAIN_OFS + ROUTE_BASE_OFS, 32'h0000_4000);
        push(16'h0123, 16'hfedc, 1'b1, 1'b1);
        `CHK(out_i, 16'h0123)
        `CHK({out_valid, marker_out, out_q}, {2'b11, 16'hfedc})
        wr(CTRL_OFS, 32'h1);
        rd(CTRL_OFS, 32'h1);
        $display("test router off done");
        for (int k = 0; k < 64; k += 8) begin
            wr(ROUTE_GAIN_OFS + ROUTE_BASE_OFS, {16'(k << 10), 16'h6000});
            push(16'h0000, 16'h0000, 1'b1, 1'b0);
            `CHK(out_i, sat(rot(ch(src_i, 1), ch(src_q, 1), 24576, k << 10, 1'b0)))
            `CHK(out_q, sat(rot(ch(src_i, 1), ch(src_q, 1), 24576, k << 10, 1'b1)))
        end
        $display("test phase sweep done");
        ei = 256;
        eq = -256;
        for (int m = 0; m < 3; m++) begin
            wr(ROUTE_BASE_OFS + 8'(m) * ROUTE_STRIDE, 32'h1 | (32'(m + 1) << SRC_LSB));
            wr(ROUTE_BASE_OFS + 8'(m) * ROUTE_STRIDE + ROUTE_GAIN_OFS, {phs[m], amps[m]});
            ei += rot(ch(src_i, m + 1), ch(src_q, m + 1), int'($signed(amps[m])), phs[m], 1'b0);
            eq += rot(ch(src_i, m + 1), ch(src_q, m + 1), int'($signed(amps[m])), phs[m], 1'b1);
        end
        push(16'h0100, 16'hff00, 1'b1, 1'b0);
        `CHK(out_i, sat(ei))
        `CHK(out_q, sat(eq))
        $display("test three routes done");
        wr(ROUTE_BASE_OFS + ROUTE_STRIDE, 32'h0);
        wr(ROUTE_BASE_OFS + 2 * ROUTE_STRIDE, 32'h0);
        wr(ROUTE_BASE_OFS + ROUTE_GAIN_OFS, 32'h0000_7fff);
        src_i <= {16'h0c00, 16'h0800, 16'h7000, 16'h1234};
        src_q <= {16'hfc00, 16'h0600, 16'h9000, 16'h0777};
        for (int n = 0; n < 4; n++) begin
            push(16'h7000, 16'h9000, (n != 3), 1'b0);
        end
        `CHK({dac_i, dac_q, dac_n}, {16'h7fff, 16'h8000, 16'd13})
        rd(OVF_COUNT_OFS, 32'h3);
        rd(STATUS_OFS, 32'h1);
        `CHK(irq, 1'b0)
        wr(MASK_OFS, 32'h1);
        @(posedge clk);
        #1 `CHK(irq, 1'b1)
        wr(STATUS_OFS, 32'h1);
        rd(STATUS_OFS, 32'h0);
        `CHK(irq, 1'b0)
        rd(OVF_COUNT_OFS, 32'h3);
        @(posedge clk);
        src_i <= {16'h0c00, 16'h0800, 16'h0000, 16'h1234};
        push(16'h0000, 16'h0000, 1'b1, 1'b0);
        `CHK(out_i, sat(rot(ch(src_i, 1), ch(src_q, 1), 32767, 0, 1'b0)))
        `CHK(out_q, sat(rot(ch(src_i, 1), ch(src_q, 1), 32767, 0, 1'b1)))
        $display("test overflow done");
        // A route fed from its own channel must be dropped rather than looped back.
        wr(ROUTE_BASE_OFS, 32'h0000_0001);
        push(16'h0100, 16'h0200, 1'b1, 1'b0);
        `CHK({out_i, out_q}, {16'h0100, 16'h0200})
        rd(STATUS_OFS, 32'h2);
        $display("test self source done");
        do_reset();
        rd(OVF_COUNT_OFS, 32'h0);
        rd(CTRL_OFS, 32'h0);
        // The router is off after reset, so the held own sample passes straight through.
        `CHK({out_i, out_q, out_valid, irq}, {16'h0100, 16'h0200, 2'b00})
        $display("test reset done");
        tally_and_finish();
    end
endmodule : output_route_adder_tb
`default_nettype wire
